// File: hdl/rx_fifo_pkg.sv
/*
 shared constants and carrier types for the receive status / fifo
 control block. assumes one 20 MHz clock and a synchronous reset.
*/
// How it works
// - bit 30 flags failed address filter
// - bits 29:16 carry frame length
// - bit 15 ors bits 11,7,6,1
// - bit 13 flags broadcast destination
// - bit 12 flags length/type mismatch
// - bit 11 flags runt under 64 bytes
// - runts forwarded only with pass-bad set
// - bit 10 flags multicast destination
// - bit 7 flags over 1518, no truncation
// - bit 6 flags late collision
// - bit 5 type frame, never short runts
// - bit 4 flags receive watchdog expiry
// - bit 3 flags receive error seen
// - bit 2 flags qualifying dribble bits
// - dribble cleared when late collision set
// - bit 1 on crc fail or rx error
// - flush resets all receive pointers
// - flush bit self-clears when done
// - one-cycle pulse when receiver halts
// - errored bulk-out packet rewinds to head
// - bulk-out data stored unaltered
// - status written at head slot last
// - frame hidden until status written
// - drop sets write pointer to head
package rx_fifo_pkg;
    localparam int          RX_PTR_W  = 13;
    localparam int          TX_PTR_W  = 11;
    localparam logic [12:0] RX_LAST   = 13'h13FF;
    localparam int          ST_FILTER = 30;
    localparam int          ST_LEN_LO = 16;
    localparam int          ST_LEN_HI = 29;
    localparam int          ST_ERR    = 15;
    localparam int          ST_BCAST  = 13;
    localparam int          ST_LENERR = 12;
    localparam int          ST_RUNT   = 11;
    localparam int          ST_MCAST  = 10;
    localparam int          ST_LONG   = 7;
    localparam int          ST_LATE   = 6;
    localparam int          ST_TYPE   = 5;
    localparam int          ST_WDOG   = 4;
    localparam int          ST_MII    = 3;
    localparam int          ST_DRIB   = 2;
    localparam int          ST_CRC    = 1;
    localparam logic [31:0] ST_RSVD   = 32'h80004301;
    localparam logic [13:0] RUNT_LEN  = 14'h0040;
    localparam logic [13:0] MAX_FRAME = 14'h05EE;
    localparam logic [13:0] WDOG_LEN  = 14'h0800;
    localparam logic [13:0] TYPE_MIN  = 14'h000E;
    localparam logic [15:0] MAX_LT    = 16'h05DC;
    localparam logic [15:0] MIN_PAY   = 16'h002E;
    localparam logic [15:0] HDR_CRC   = 16'h0012;
    localparam logic [15:0] MIN_FRAME = 16'h0040;
    localparam logic [2:0]  DRIB_MII  = 3'h4;
    localparam logic [2:0]  DRIB_10M  = 3'h3;
    localparam logic [11:0] A_MAC_CTL = 12'h000;
    localparam logic [11:0] A_RX_CFG  = 12'h004;
    localparam logic [11:0] A_RX_STAT = 12'h008;
    localparam logic [11:0] A_TX_STAT = 12'h00C;
    localparam int          MC_RECEIVER_ENABLE_BIT   = 2;
    localparam int          MC_PASSBD = 16;
    localparam int          RC_FLUSH  = 0;
    localparam logic [31:0] MC_RESET  = 32'h00000000;

    typedef struct packed {
        logic [13:0] len;
        logic [15:0] lt_field;
        logic        filter_fail;
        logic        broadcast;
        logic        multicast;
        logic        late_col;
        logic        rx_err;
        logic        crc_bad;
        logic [2:0]  dribble;
        logic        ten_mbps;
    } rx_frame_info_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
        logic        last;
        logic        bad;
    } tx_beat_t;
endpackage

// File: hdl/rx_status_former.sv
/*
 builds the receive status word from the frame summary.
 assumes the summary is stable in the cycle the frame ends.
*/
`timescale 1ns/1ps
module rx_status_former (
    // frame summary
    input  rx_fifo_pkg::rx_frame_info_t INFO,
    // status word
    output logic [31:0]                 STATUS
);
    wire         runt  = INFO.len < rx_fifo_pkg::RUNT_LEN;
    wire         tlong = INFO.len > rx_fifo_pkg::MAX_FRAME;
    wire         wdog  = INFO.len > rx_fifo_pkg::WDOG_LEN;
    wire         is_ty = INFO.lt_field > rx_fifo_pkg::MAX_LT;
    wire         short = INFO.len < rx_fifo_pkg::TYPE_MIN;
    wire [15:0]  want  = (INFO.lt_field < rx_fifo_pkg::MIN_PAY)
                       ? rx_fifo_pkg::MIN_FRAME
                       : INFO.lt_field + rx_fifo_pkg::HDR_CRC;
    // frames under 14 bytes carry no length/type data to compare
    wire         lerr  = !is_ty && !short && (want != {2'h0, INFO.len});
    wire         drib  = INFO.ten_mbps
                       ? INFO.dribble >= rx_fifo_pkg::DRIB_10M
                       : INFO.dribble == rx_fifo_pkg::DRIB_MII;
    wire         crc   = INFO.crc_bad || INFO.rx_err;

    always_comb
    begin
        STATUS = 32'h00000000;
        STATUS[rx_fifo_pkg::ST_FILTER] = INFO.filter_fail;
        STATUS[rx_fifo_pkg::ST_LEN_HI:rx_fifo_pkg::ST_LEN_LO] = INFO.len;
        STATUS[rx_fifo_pkg::ST_ERR] = runt | tlong | INFO.late_col | crc;
        STATUS[rx_fifo_pkg::ST_BCAST] = INFO.broadcast;
        STATUS[rx_fifo_pkg::ST_LENERR] = lerr;
        STATUS[rx_fifo_pkg::ST_RUNT] = runt;
        STATUS[rx_fifo_pkg::ST_MCAST] = INFO.multicast;
        STATUS[rx_fifo_pkg::ST_LONG] = tlong;
        STATUS[rx_fifo_pkg::ST_LATE] = INFO.late_col;
        STATUS[rx_fifo_pkg::ST_TYPE] = is_ty && !short;
        STATUS[rx_fifo_pkg::ST_WDOG] = wdog;
        STATUS[rx_fifo_pkg::ST_MII] = INFO.rx_err;
        STATUS[rx_fifo_pkg::ST_DRIB] = drib && !INFO.late_col;
        STATUS[rx_fifo_pkg::ST_CRC] = crc;
    end
endmodule // rx_status_former

// File: hdl/tx_write_ptrs.sv
/*
 transmit fifo write side: stores bulk-out words and rewinds errored
 packets. assumes the read side reports its pointer on this clock.
*/
`timescale 1ns/1ps
module tx_write_ptrs (
    // clock and reset
    input  wire logic                  CLK,
    input  wire logic                  RESET,
    // bulk-out beats
    input  rx_fifo_pkg::tx_beat_t      BEAT,
    output logic                       READY,
    // read side pointer, wrap bit on top
    input  wire logic [11:0]           RD_PTR,
    // memory write port and pointers
    output logic                       MEM_WE,
    output logic [10:0]                MEM_ADDR,
    output logic [31:0]                MEM_WDATA,
    output logic [11:0]                WR_PTR,
    output logic [11:0]                HEAD_PTR
);
    wire wrap_diff = WR_PTR[rx_fifo_pkg::TX_PTR_W]
                   != RD_PTR[rx_fifo_pkg::TX_PTR_W];
    wire same_slot = WR_PTR[10:0] == RD_PTR[10:0];
    wire store     = BEAT.valid && READY;
    wire ends      = BEAT.last && !BEAT.valid;

    assign READY = !(wrap_diff && same_slot);

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            WR_PTR    <= 12'h000;
            HEAD_PTR  <= 12'h000;
            MEM_WE    <= 1'b0;
            MEM_ADDR  <= 11'h000;
            MEM_WDATA <= 32'h00000000;
        end
        else
        begin
            MEM_WE <= store;
            if (store)
            begin
                MEM_ADDR  <= WR_PTR[10:0];
                MEM_WDATA <= BEAT.data;
                WR_PTR    <= WR_PTR + 12'h001;
            end
            else if (ends && BEAT.bad)
                WR_PTR <= HEAD_PTR;
            else if (ends)
                HEAD_PTR <= WR_PTR;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    a_tx_rewind_head: assert property (
        ends && BEAT.bad |=> WR_PTR == $past(HEAD_PTR))
        else $error("tx write pointer not rewound");
    a_tx_data_copy: assert property (
        store |=> MEM_WE && MEM_WDATA == $past(BEAT.data))
        else $error("tx data altered");
    c_tx_rewind: cover property (ends && BEAT.bad);
endmodule // tx_write_ptrs

// File: hdl/rx_status_and_fifo_control.sv
/*
 receive status and fifo pointer control with apb registers, plus the
 transmit write side. assumes the mac and usb engines share CLK and
 that the fifo rams sit outside, fed by the write and read ports here.
*/
`timescale 1ns/1ps
module rx_status_and_fifo_control (
    // clock and reset
    input  wire logic                  CLK,
    input  wire logic                  RESET,
    // apb slave
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [11:0]           PADDR,
    input  wire logic [31:0]           PWDATA,
    output logic [31:0]                PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    // mac transfer interface, receive
    input  wire logic                  RX_DATA_VALID,
    input  wire logic [31:0]           RX_DATA,
    input  wire logic                  RX_FRAME_END,
    input  rx_fifo_pkg::rx_frame_info_t RX_INFO,
    output logic                       RECEIVER_ENABLE,
    output logic                       RECEIVER_STOPPED_PULSE,
    // receive fifo ram write port
    output logic                       RX_MEM_WE,
    output logic [12:0]                RX_MEM_ADDR,
    output logic [31:0]                RX_MEM_WDATA,
    // usb in transmitter read side
    input  wire logic                  RX_RD_POP,
    input  wire logic                  RX_RD_MARK,
    input  wire logic                  RX_RD_REWIND,
    output logic                       RX_AVAIL,
    output logic [12:0]                RX_RD_ADDR,
    // usb out receiver, transmit fifo write side
    input  rx_fifo_pkg::tx_beat_t      TX_BEAT,
    output logic                       TX_READY,
    input  wire logic [11:0]           TX_RD_PTR,
    output logic                       TX_MEM_WE,
    output logic [10:0]                TX_MEM_ADDR,
    output logic [31:0]                TX_MEM_WDATA,
    output logic [11:0]                TX_HEAD_PTR
);
    typedef enum logic [1:0] {IDLE, RECV, DROP} rx_state_t;

    rx_state_t   state;
    rx_state_t   next_state;
    logic [31:0] mac_control_reg;
    logic        flush_bit;
    logic [12:0] rx_wr;
    logic [12:0] rx_hd;
    logic [12:0] rx_rd;
    logic [12:0] rx_rd_hd;
    logic        stopped_q;
    logic        status_wr;
    logic [31:0] status_word;
    logic [11:0] tx_wr;

    function automatic logic [12:0] ptr_inc(input logic [12:0] p);
        ptr_inc = (p == rx_fifo_pkg::RX_LAST) ? 13'h0000 : p + 13'h0001;
    endfunction

    rx_status_former u_status (
        .INFO   (RX_INFO),
        .STATUS (status_word)
    );

    tx_write_ptrs u_tx (
        .CLK       (CLK),
        .RESET     (RESET),
        .BEAT      (TX_BEAT),
        .READY     (TX_READY),
        .RD_PTR    (TX_RD_PTR),
        .MEM_WE    (TX_MEM_WE),
        .MEM_ADDR  (TX_MEM_ADDR),
        .MEM_WDATA (TX_MEM_WDATA),
        .WR_PTR    (tx_wr),
        .HEAD_PTR  (TX_HEAD_PTR)
    );

    // control bits
    wire receiver_enable_bit = mac_control_reg[rx_fifo_pkg::MC_RECEIVER_ENABLE_BIT];
    wire pass_bad = mac_control_reg[rx_fifo_pkg::MC_PASSBD];

    // apb decode
    wire hit_mac = PADDR == rx_fifo_pkg::A_MAC_CTL;
    wire hit_cfg = PADDR == rx_fifo_pkg::A_RX_CFG;
    wire hit_rst = PADDR == rx_fifo_pkg::A_RX_STAT;
    wire hit_tst = PADDR == rx_fifo_pkg::A_TX_STAT;
    wire mapped  = hit_mac || hit_cfg || hit_rst || hit_tst;
    wire access  = PSEL && PENABLE;
    wire wr_ok   = access && PWRITE && mapped;
    wire wr_mac  = wr_ok && hit_mac;
    wire wr_cfg  = wr_ok && hit_cfg;
    wire set_fl  = wr_cfg && PWDATA[rx_fifo_pkg::RC_FLUSH];

    // receiver halts only between frames
    wire stopped = !receiver_enable_bit && state == IDLE;
    // the host must stop first; a flush requested while running waits
    wire flush_go = flush_bit && stopped;

    wire [31:0] rx_stat_word = {3'h0, rx_hd, 14'h0000, RX_AVAIL, stopped};
    wire [31:0] tx_stat_word = {4'h0, TX_HEAD_PTR, 4'h0, tx_wr};
    wire [31:0] cfg_word     = {31'h00000000, flush_bit};
    wire [31:0] rd_mux = hit_mac ? mac_control_reg
                       : hit_cfg ? cfg_word
                       : hit_rst ? rx_stat_word
                       : hit_tst ? tx_stat_word
                       : 32'h00000000;

    assign PREADY  = 1'b1;
    assign PSLVERR = access && !mapped;

    // receive write side
    wire beat     = RX_DATA_VALID
                  && (state == RECV || (state == IDLE && receiver_enable_bit));
    wire [12:0] cur = (state == IDLE) ? ptr_inc(rx_hd) : rx_wr;
    wire overflow = beat && (cur == rx_rd || ptr_inc(cur) == rx_rd);
    wire store    = beat && !overflow;
    wire done     = RX_FRAME_END && state == RECV && !RX_DATA_VALID;
    wire runt     = status_word[rx_fifo_pkg::ST_RUNT];
    wire keep     = done && (!runt || pass_bad);
    wire drop     = done && !keep;

    assign RECEIVER_ENABLE = receiver_enable_bit;
    // frames become visible only once the head moves past them
    assign RX_AVAIL = rx_rd != rx_hd;
    assign RX_RD_ADDR = rx_rd;

    always_comb
    begin
        next_state = state;
        case (state)
            IDLE:
                if (beat)
                    next_state = overflow ? DROP : RECV;
            RECV:
                if (done)
                    next_state = IDLE;
                else if (overflow)
                    next_state = DROP;
            DROP:
                // rest of an overflowed frame is ignored
                if (RX_FRAME_END)
                    next_state = IDLE;
            default:
                next_state = IDLE;
        endcase
    end

    // registers
    always_ff @(posedge CLK)
    begin
        if (RESET)
            mac_control_reg <= rx_fifo_pkg::MC_RESET;
        else if (wr_mac)
            mac_control_reg <= PWDATA;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            flush_bit <= 1'b0;
        else if (set_fl)
            flush_bit <= 1'b1;
        else if (flush_go)
            flush_bit <= 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            PRDATA <= 32'h00000000;
        else if (PSEL && !PENABLE && !PWRITE)
            PRDATA <= rd_mux;
    end

    // stop pulse; reset high so no pulse right after reset
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            stopped_q              <= 1'b1;
            RECEIVER_STOPPED_PULSE <= 1'b0;
        end
        else
        begin
            stopped_q              <= stopped;
            RECEIVER_STOPPED_PULSE <= stopped && !stopped_q;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            state <= IDLE;
        else if (flush_go)
            state <= IDLE;
        else
            state <= next_state;
    end

    // write pointers
    always_ff @(posedge CLK)
    begin
        if (RESET || flush_go)
        begin
            rx_wr <= 13'h0000;
            rx_hd <= 13'h0000;
        end
        else if (overflow || drop)
            rx_wr <= rx_hd;
        else if (store)
            rx_wr <= ptr_inc(cur);
        else if (keep)
            rx_hd <= rx_wr;
    end

    // read pointers
    always_ff @(posedge CLK)
    begin
        if (RESET || flush_go)
        begin
            rx_rd    <= 13'h0000;
            rx_rd_hd <= 13'h0000;
        end
        else if (RX_RD_REWIND)
            rx_rd <= rx_rd_hd;
        else if (RX_RD_MARK)
            rx_rd_hd <= rx_rd;
        else if (RX_RD_POP && RX_AVAIL)
            rx_rd <= ptr_inc(rx_rd);
    end

    // ram write port; status goes to the head slot as the last word
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            RX_MEM_WE    <= 1'b0;
            RX_MEM_ADDR  <= 13'h0000;
            RX_MEM_WDATA <= 32'h00000000;
            status_wr    <= 1'b0;
        end
        else
        begin
            RX_MEM_WE <= (store || keep) && !flush_go;
            status_wr <= keep && !flush_go;
            if (keep)
            begin
                RX_MEM_ADDR  <= rx_hd;
                RX_MEM_WDATA <= status_word;
            end
            else if (store)
            begin
                RX_MEM_ADDR  <= cur;
                RX_MEM_WDATA <= RX_DATA;
            end
        end
    end

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    a_status_reserved: assert property (
        status_wr |-> (RX_MEM_WDATA & rx_fifo_pkg::ST_RSVD) == 32'h00000000)
        else $error("reserved status bits not zero");

    a_error_summary: assert property (
        status_wr |-> RX_MEM_WDATA[rx_fifo_pkg::ST_ERR] ==
            (RX_MEM_WDATA[rx_fifo_pkg::ST_RUNT]
             | RX_MEM_WDATA[rx_fifo_pkg::ST_LONG]
             | RX_MEM_WDATA[rx_fifo_pkg::ST_LATE]
             | RX_MEM_WDATA[rx_fifo_pkg::ST_CRC]))
        else $error("error summary bit wrong");

    a_dribble_late: assert property (
        status_wr && RX_MEM_WDATA[rx_fifo_pkg::ST_LATE]
            |-> !RX_MEM_WDATA[rx_fifo_pkg::ST_DRIB])
        else $error("dribble set with late collision");

    a_status_at_head: assert property (
        keep && !flush_go |=> status_wr && RX_MEM_ADDR == $past(rx_hd)
            ##1 !status_wr)
        else $error("status not written at head slot");

    a_runt_dropped: assert property (
        done && runt && !pass_bad |=> rx_wr == rx_hd && !status_wr)
        else $error("runt frame kept without pass-bad");

    a_hidden_frame: assert property (
        state == RECV && !keep && !flush_go |=> $stable(rx_hd))
        else $error("head moved before status written");

    a_flush_pointers: assert property (
        flush_go |=> rx_rd == 13'h0000 && rx_wr == 13'h0000
            && rx_hd == 13'h0000 && !RX_AVAIL)
        else $error("flush left pointers set");

    a_flush_selfclear: assert property (
        flush_go && !set_fl |=> !flush_bit)
        else $error("flush bit did not clear");

    a_stop_pulse_single: assert property (
        RECEIVER_STOPPED_PULSE |-> $past(stopped) ##1
            !RECEIVER_STOPPED_PULSE)
        else $error("stop pulse wrong");

    a_overflow_rewind: assert property (
        overflow |=> rx_wr == $past(rx_hd) && state == DROP)
        else $error("overflow did not rewind");

    a_read_rewind: assert property (
        RX_RD_REWIND && !flush_go |=> rx_rd == $past(rx_rd_hd))
        else $error("read rewind missed head");

    a_runt_passed: assert property (
        done && runt && pass_bad |=> status_wr)
        else $error("runt dropped with pass-bad");

    a_word_stored: assert property (
        store |=> RX_MEM_WE && RX_MEM_WDATA == $past(RX_DATA))
        else $error("received word lost");

    a_status_length: assert property (
        status_wr |-> RX_MEM_WDATA[rx_fifo_pkg::ST_LEN_HI:
            rx_fifo_pkg::ST_LEN_LO] == $past(RX_INFO.len))
        else $error("status length wrong");

    a_flush_waits: assert property (
        flush_bit && !stopped |=> flush_bit)
        else $error("flush ran while receiving");

    c_frame_kept: cover property (keep);
    c_frame_overflow: cover property (overflow);
    c_flush_done: cover property (flush_go);
    c_stop_pulse: cover property (RECEIVER_STOPPED_PULSE);
endmodule // rx_status_and_fifo_control

// File: test/mac_rx_model.sv
/*
 behavioural mac receive side: sends a frame of dwords, then the
 frame end with its summary. assumes one clock shared with the block.
*/
`timescale 1ns/1ps
module mac_rx_model (
    // clock
    input  wire logic                   CLK,
    // frame request from the bench
    input  wire logic                   START,
    input  wire logic [3:0]             NWORDS,
    input  wire logic [31:0]            BASE,
    input  rx_fifo_pkg::rx_frame_info_t INFO,
    output logic                        BUSY,
    // mac transfer interface
    output logic                        VALID,
    output logic [31:0]                 DATA,
    output logic                        FRAME_END,
    output rx_fifo_pkg::rx_frame_info_t INFO_OUT
);
    logic [3:0] cnt;

    initial
    begin
        BUSY = 1'b0;
        VALID = 1'b0;
        FRAME_END = 1'b0;
        DATA = 32'h00000000;
        INFO_OUT = '0;
        cnt = 4'h0;
    end

    // idle lines flip every cycle so stale values never look valid
    always @(posedge CLK)
    begin
        VALID <= 1'b0;
        FRAME_END <= 1'b0;
        DATA <= ~DATA;
        INFO_OUT <= ~INFO_OUT;
        if (START && !BUSY)
        begin
            BUSY <= 1'b1;
            cnt <= 4'h0;
        end
        else if (BUSY && cnt == NWORDS)
        begin
            FRAME_END <= 1'b1;
            INFO_OUT <= INFO;
            BUSY <= 1'b0;
        end
        else if (BUSY && ($urandom % 4 != 0))
        begin
            VALID <= 1'b1;
            DATA <= BASE + 32'(cnt);
            cnt <= cnt + 4'h1;
        end
    end
endmodule // mac_rx_model

// File: test/rx_status_and_fifo_control_test.sv
/*
 self-checking bench: frames, stop, flush and transmit rewind.
 assumes apb answers at once and the mac model shares the clock.
*/
`timescale 1ns/1ps
module rx_status_and_fifo_control_test;
    logic clk, reset, psel, penable, pwrite, start, busy, m_valid, m_end;
    logic pop, pop_on, hide, pready, pslverr, rx_we, tx_we, stop_pulse;
    logic [11:0] paddr, tx_head;
    logic [31:0] pwdata, prdata, m_data, rx_wdata, tx_wdata, base, rd;
    logic [12:0] rx_addr, rd_addr, head;
    logic [10:0] tx_addr, txw;
    logic [3:0] nwords;
    logic err, avail, rx_en, mark, rew, tx_rdy;
    rx_fifo_pkg::rx_frame_info_t info, m_info, f;
    rx_fifo_pkg::tx_beat_t beat;
    logic [45:0] note[$];
    int num_errors, compares, cycles;

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    rx_status_and_fifo_control i_rx_status_and_fifo_control (
        .CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .RX_DATA_VALID(m_valid),
        .RX_DATA(m_data), .RX_FRAME_END(m_end), .RX_INFO(m_info),
        .RECEIVER_ENABLE(rx_en), .RECEIVER_STOPPED_PULSE(stop_pulse),
        .RX_MEM_WE(rx_we), .RX_MEM_ADDR(rx_addr), .RX_MEM_WDATA(rx_wdata),
        .RX_RD_POP(pop), .RX_RD_MARK(mark), .RX_RD_REWIND(rew),
        .RX_AVAIL(avail), .RX_RD_ADDR(rd_addr), .TX_BEAT(beat),
        .TX_READY(tx_rdy), .TX_RD_PTR(12'h000), .TX_MEM_WE(tx_we),
        .TX_MEM_ADDR(tx_addr), .TX_MEM_WDATA(tx_wdata),
        .TX_HEAD_PTR(tx_head));

    mac_rx_model i_mac_rx_model (
        .CLK(clk), .START(start), .NWORDS(nwords), .BASE(base),
        .INFO(info), .BUSY(busy), .VALID(m_valid), .DATA(m_data),
        .FRAME_END(m_end), .INFO_OUT(m_info));

    task automatic check(input string what, input logic [45:0] seen,
                         input logic [45:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // timeout and the result watcher
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            num_errors++;
            complete_run();
        end
        pop <= pop_on && ($urandom % 2 == 1);
        if (rx_we === 1'b1)
            check("rx ram", {1'b0, rx_addr, rx_wdata}, note.pop_front());
        if (tx_we === 1'b1)
            check("tx ram", {3'h4, tx_addr, tx_wdata}, note.pop_front());
        if (m_end === 1'b1 && hide)
            check("hidden frame", avail, 1'b0);
    end

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] exp_status(
        input rx_fifo_pkg::rx_frame_info_t s);
        logic [31:0] w;
        logic [15:0] want;
        w = 32'h00000000;
        want = (s.lt_field < 16'h002E) ? 16'h0040 : s.lt_field + 16'h0012;
        w[30] = s.filter_fail;
        w[29:16] = s.len;
        w[13] = s.broadcast;
        w[12] = s.len >= 14 && s.lt_field <= 1500 && 16'(s.len) != want;
        w[11] = s.len < 64;
        w[10] = s.multicast;
        w[7] = s.len > 1518;
        w[6] = s.late_col;
        w[5] = s.len >= 14 && s.lt_field > 1500;
        w[4] = s.len > 2048;
        w[3] = s.rx_err;
        w[2] = !s.late_col && (s.ten_mbps ? s.dribble >= 3 : s.dribble == 4);
        w[1] = s.crc_bad | s.rx_err;
        w[15] = w[11] | w[7] | w[6] | w[1];
        return w;
    endfunction

    task automatic frame(input logic keep);
        nwords <= 4'($urandom_range(1, 6));
        base <= $urandom;
        info <= f;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int k = 0; k < nwords; k++)
            note.push_back({1'b0, head + 13'(k + 1), base + 32'(k)});
        // runts vanish without pass-bad, so the head stays put
        if (keep)
            note.push_back({1'b0, head, exp_status(f)});
        if (keep)
            head = head + 13'(nwords) + 13'h1;
        do @(posedge clk); while (busy === 1'b1);
        repeat (3) @(posedge clk);
    endtask

    task automatic tx_packet(input logic bad);
        logic [31:0] d;
        for (int k = 0; k < 3; k++)
        begin
            d = $urandom;
            note.push_back({3'h4, txw + 11'(k), d});
            @(posedge clk);
            beat <= '{1'b1, d, 1'b0, 1'b0};
        end
        @(posedge clk);
        beat <= '{1'b0, 32'h00000000, 1'b1, bad};
        @(posedge clk);
        beat <= '0;
        if (!bad)
            txw = txw + 11'h3;
        repeat (3) @(posedge clk);
        check("tx head", tx_head, {1'b0, txw});
        check("tx ready", tx_rdy, 1'b1);
    endtask

    initial
    begin
        {psel, penable, pwrite, start, pop_on, hide, mark, rew} = '0;
        {paddr, pwdata, nwords, base, info, beat} = '0;
        reset = 1'b1;
        head = 13'h0000;
        txw = 11'h000;
        void'($urandom(32'h8063));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, 12'h000, 32'h00000000);
        check("mac control reset", rd, 32'h00000000);
        apb(1'b0, 12'hFFC, 32'h00000000);
        check("unmapped error", {err, rd}, 33'h100000000);
        apb(1'b1, 12'h000, 32'h00010004);
        @(posedge clk);
        check("receiver enable", rx_en, 1'b1);
        pop_on = 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            if (i == 6)
                apb(1'b1, 12'h000, 32'h00000004);
            f = 40'({$urandom, $urandom});
            f.len = 14'(i % 3 == 0 ? $urandom_range(0, 70)
                                   : $urandom_range(0, 2600));
            if (i % 2 == 0)
                f.lt_field = 16'(f.len) - 16'h0012;
            frame(i < 6 || f.len >= 64);
        end
        tx_packet(1'b1);
        tx_packet(1'b0);
        apb(1'b0, 12'h00C, 32'h00000000);
        check("tx status", rd, {16'(txw), 16'(txw)});
        pop_on = 1'b0;
        apb(1'b1, 12'h000, 32'h00000000);
        for (int w = 0; w < 50 && stop_pulse !== 1'b1; w++)
            @(posedge clk);
        check("stop pulse", stop_pulse, 1'b1);
        @(posedge clk);
        check("stop pulse end", stop_pulse, 1'b0);
        apb(1'b1, 12'h004, 32'h00000001);
        repeat (2) @(posedge clk);
        apb(1'b0, 12'h004, 32'h00000000);
        check("flush bit", rd[0], 1'b0);
        check("read pointer", rd_addr, 13'h0000);
        apb(1'b0, 12'h008, 32'h00000000);
        check("rx status", rd, 32'h00000001);
        head = 13'h0000;
        hide = 1'b1;
        apb(1'b1, 12'h000, 32'h00000004);
        f.len = 14'h0100;
        frame(1'b1);
        check("frame visible", avail, 1'b1);
        pop_on = 1'b1;
        repeat (3) @(posedge clk);
        pop_on = 1'b0;
        @(posedge clk);
        mark <= 1'b1;
        @(posedge clk);
        mark <= 1'b0;
        rd = 32'(rd_addr);
        pop_on = 1'b1;
        repeat (4) @(posedge clk);
        pop_on = 1'b0;
        @(posedge clk);
        rew <= 1'b1;
        @(posedge clk);
        rew <= 1'b0;
        @(posedge clk);
        check("read rewind", rd_addr, rd[12:0]);
        check("notes left", note.size(), 0);
        complete_run();
    end
endmodule // rx_status_and_fifo_control_test
